// ===== wrxs_defines.svh
`ifndef WRXS_DEFINES_SVH
`define WRXS_DEFINES_SVH

// ****************************************************************
// timing
// ****************************************************************
`define WRXS_CLK_NS        50
`define WRXS_BIT_NS        500000
`define WRXS_BIT_CYC       (`WRXS_BIT_NS / `WRXS_CLK_NS)
`define WRXS_CE_GAP_MS     250
`define WRXS_CE_GAP_CYC    ((`WRXS_CE_GAP_MS * 1000000) / `WRXS_CLK_NS)
`define WRXS_STRAP_NS      100000
`define WRXS_STRAP_CYC     (`WRXS_STRAP_NS / `WRXS_CLK_NS)
`define WRXS_OC_TRIES      4'hc

// ****************************************************************
// packet headers and payloads
// ****************************************************************
`define WRXS_HDR_SIG       8'h01
`define WRXS_HDR_ID        8'h71
`define WRXS_HDR_CFG       8'h51
`define WRXS_HDR_CE        8'h03
`define WRXS_HDR_EPT       8'h02
`define WRXS_EPT_UNKNOWN   8'h00
`define WRXS_EPT_CHARGED   8'h01
`define WRXS_OVERCURRENT_END_PACKET        8'h04
`define WRXS_PKT_BITS      5'h10

// ****************************************************************
// strap adc windows (100 ua into the strap, 1.8 v full scale)
// ****************************************************************
`define WRXS_IOC_GND_MAX   8'h10
`define WRXS_IOC_260_MAX   8'h3c
`define WRXS_IOC_540_MAX   8'h6f
`define WRXS_OUTPUT_LEVEL_STRAP_GND_MAX  8'h18
`define WRXS_OUTPUT_LEVEL_STRAP_450_MAX  8'h36
`define WRXS_OUTPUT_LEVEL_STRAP_475_MAX  8'h44
`define WRXS_OUTPUT_LEVEL_STRAP_525_MAX  8'h54
`define WRXS_OUTPUT_LEVEL_STRAP_550_MAX  8'h64
`define WRXS_OUTPUT_LEVEL_STRAP_575_MAX  8'h77
`define WRXS_HDR_LO_MAX    8'h14

// ****************************************************************
// current codes, 4 ma per lsb
// ****************************************************************
`define WRXS_ILIM_260      8'h41
`define WRXS_ILIM_540      8'h87
`define WRXS_ILIM_780      8'hc3
`define WRXS_DUMMY_MIN     8'h0a

// ****************************************************************
// rectifier and output codes, 50 mv per lsb
// ****************************************************************
`define WRXS_BRIDGE_OUTPUT_NODE_NOLOAD   8'h82
`define WRXS_VOUT_450      8'h5a
`define WRXS_VOUT_475      8'h5f
`define WRXS_VOUT_500      8'h64
`define WRXS_VOUT_525      8'h69
`define WRXS_VOUT_550      8'h6e
`define WRXS_VOUT_575      8'h73
`define WRXS_VOUT_600      8'h78
`define WRXS_HEAD_LO       8'h06
`define WRXS_HEAD_HI       8'h0a

`endif

// ===== wrxs_pkg.sv
package wrxs_pkg;

  typedef enum logic [7:0]
  {
    st_off   = 8'h01,
    st_strap = 8'h02,
    st_sig   = 8'h04,
    st_id    = 8'h08,
    st_cfg   = 8'h10,
    st_xfer  = 8'h20,
    st_ept   = 8'h40,
    st_done  = 8'h80
  } wrxs_state_e;

endpackage : wrxs_pkg

// ===== wrxs_seq.sv
`timescale 1ns/100ps
`include "wrxs_defines.svh"
//
// Function
// - after power-up send signal strength, identification, configuration, then transfer
// - during power transfer send control error packets periodically
// - keep dummy load on until external load suffices for modulation
// - charge done high sends charge-complete end packet then shuts down
// - enable_n high sends end packet, output high impedance; low runs
// - over-current sends end packet, resent up to 12 transmissions
// - over-current from adc current code compared with threshold
// - current limit strap at ground disables over-current protection
// - strap 2.26k/6.19k/9.53k maps to 260/540/780 ma trip
// - output level strap picks one of seven levels; ground gives 5.00
// - pulse 100 ua strap current while reading the current limit strap
// - power link indicator pulled low while power is transferred
// - rectifier target 6.5 v at no load, load-based after handshake
// - headroom strap 1.13k for up to 400 ma, 1.69k above
// - packets go out by load modulation at 2 kbps
module wrxs_seq #(
  parameter int unsigned BIT_CYC    = `WRXS_BIT_CYC,
  parameter int unsigned CE_GAP_CYC = `WRXS_CE_GAP_CYC,
  parameter logic [7:0]  RX_ID      = 8'h5a,  // arbitrary value
  parameter logic [7:0]  CFG_WORD   = 8'h06
)(
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       ping_power_good,
  input  wire logic       charge_done,
  input  wire logic       enable_n,
  input  wire logic [7:0] load_current_code,
  input  wire logic [7:0] bridge_output_node_voltage_code,
  input  wire logic [7:0] ioc_strap_code,
  input  wire logic [7:0] output_level_strap_strap_code,
  input  wire logic [7:0] hdr_strap_code,
  output logic            mod_drive,
  output logic            dummy_load_en,
  output logic            strap_current_en,
  output logic            out_hiz,
  output logic            power_link_indicator_o,
  output logic            power_link_indicator_oe,
  output logic            ocp_enabled,
  output logic [2:0]      output_level_sel,
  output logic            headroom_hi,
  output logic [7:0]      bridge_output_node_target
);

  // ****************************************************************
  // state
  // ****************************************************************
  wrxs_pkg::wrxs_state_e st_ff,    nxt_st;
  logic                  busy_ff,  nxt_busy;
  logic [15:0]           sh_ff,    nxt_sh;
  logic [4:0]            bitc_ff,  nxt_bitc;
  logic [31:0]           btmr_ff,  nxt_btmr;
  logic [31:0]           gtmr_ff,  nxt_gtmr;
  logic                  mod_ff,   nxt_mod;
  logic                  dum_ff,   nxt_dum;
  logic                  isrc_ff,  nxt_isrc;
  logic                  hiz_ff,   nxt_hiz;
  logic                  link_ff,  nxt_link;
  logic                  ocpe_ff,  nxt_ocpe;
  logic [7:0]            ilim_ff,  nxt_ilim;
  logic [2:0]            vsel_ff,  nxt_vsel;
  logic                  hdr_ff,   nxt_hdr;
  logic [7:0]            tgt_ff,   nxt_tgt;
  logic                  ocm_ff,   nxt_ocm;
  logic [3:0]            tries_ff, nxt_tries;
  logic [15:0]           ept_ff,   nxt_ept;

  // ****************************************************************
  // next-state logic
  // ****************************************************************
  always_comb
  begin
    logic       tx_done;
    logic       tx_go;
    logic [15:0] tx_word;
    logic       oc_trip;
    logic [7:0] vout;
    logic [7:0] head;
    tx_done   = 1'b0;
    tx_go     = 1'b0;
    tx_word   = 16'h0000;
    oc_trip   = 1'b0;
    vout      = `WRXS_VOUT_500;
    head      = `WRXS_HEAD_LO;
    nxt_st    = st_ff;
    nxt_busy  = busy_ff;
    nxt_sh    = sh_ff;
    nxt_bitc  = bitc_ff;
    nxt_btmr  = btmr_ff;
    nxt_gtmr  = gtmr_ff;
    nxt_mod   = mod_ff;
    nxt_isrc  = 1'b0;
    nxt_ocpe  = ocpe_ff;
    nxt_ilim  = ilim_ff;
    nxt_vsel  = vsel_ff;
    nxt_hdr   = hdr_ff;
    nxt_ocm   = ocm_ff;
    nxt_tries = tries_ff;
    nxt_ept   = ept_ff;

    // serialiser: one level per bit cell, msb first
    if (busy_ff)
    begin
      if (btmr_ff == BIT_CYC - 1)
      begin
        nxt_btmr = 32'h0;
        if (bitc_ff == `WRXS_PKT_BITS - 5'h01)
        begin
          nxt_busy = 1'b0;
          nxt_mod  = 1'b0;
          tx_done  = 1'b1;
        end
        else
        begin
          nxt_bitc = bitc_ff + 5'h01;
          nxt_sh   = {sh_ff[14:0], 1'b0};
          nxt_mod  = sh_ff[14];
        end
      end
      else
        nxt_btmr = btmr_ff + 32'h1;
    end

    case (vsel_ff)
      3'h0:    vout = `WRXS_VOUT_450;
      3'h1:    vout = `WRXS_VOUT_475;
      3'h3:    vout = `WRXS_VOUT_525;
      3'h4:    vout = `WRXS_VOUT_550;
      3'h5:    vout = `WRXS_VOUT_575;
      3'h6:    vout = `WRXS_VOUT_600;
      default: vout = `WRXS_VOUT_500;
    endcase
    head = hdr_ff ? `WRXS_HEAD_HI : `WRXS_HEAD_LO;
    nxt_tgt = (st_ff == wrxs_pkg::st_xfer) ?
              vout + head + {3'h0, load_current_code[7:3]} :
              `WRXS_BRIDGE_OUTPUT_NODE_NOLOAD;
    oc_trip = ocpe_ff && (load_current_code > ilim_ff);

    case (st_ff)
      wrxs_pkg::st_off:
      begin
        nxt_ocm = 1'b0;
        nxt_tries = 4'h0;
        if (ping_power_good && !enable_n)
        begin
          nxt_st   = wrxs_pkg::st_strap;
          nxt_gtmr = 32'h0;
          nxt_isrc = 1'b1;
        end
      end
      wrxs_pkg::st_strap:
      begin
        nxt_isrc = 1'b1;
        nxt_gtmr = gtmr_ff + 32'h1;
        if (gtmr_ff == `WRXS_STRAP_CYC - 1)
        begin
          nxt_isrc = 1'b0;
          nxt_ocpe = ioc_strap_code >= `WRXS_IOC_GND_MAX;
          if (ioc_strap_code < `WRXS_IOC_260_MAX)
            nxt_ilim = `WRXS_ILIM_260;
          else if (ioc_strap_code < `WRXS_IOC_540_MAX)
            nxt_ilim = `WRXS_ILIM_540;
          else
            nxt_ilim = `WRXS_ILIM_780;
          if (output_level_strap_strap_code < `WRXS_OUTPUT_LEVEL_STRAP_GND_MAX)
            nxt_vsel = 3'h2;
          else if (output_level_strap_strap_code < `WRXS_OUTPUT_LEVEL_STRAP_450_MAX)
            nxt_vsel = 3'h0;
          else if (output_level_strap_strap_code < `WRXS_OUTPUT_LEVEL_STRAP_475_MAX)
            nxt_vsel = 3'h1;
          else if (output_level_strap_strap_code < `WRXS_OUTPUT_LEVEL_STRAP_525_MAX)
            nxt_vsel = 3'h3;
          else if (output_level_strap_strap_code < `WRXS_OUTPUT_LEVEL_STRAP_550_MAX)
            nxt_vsel = 3'h4;
          else if (output_level_strap_strap_code < `WRXS_OUTPUT_LEVEL_STRAP_575_MAX)
            nxt_vsel = 3'h5;
          else
            nxt_vsel = 3'h6;
          nxt_hdr = hdr_strap_code >= `WRXS_HDR_LO_MAX;
          nxt_st  = wrxs_pkg::st_sig;
          tx_go   = 1'b1;
          tx_word = {`WRXS_HDR_SIG, bridge_output_node_voltage_code};
        end
      end
      wrxs_pkg::st_sig, wrxs_pkg::st_id, wrxs_pkg::st_cfg,
      wrxs_pkg::st_xfer:
      begin
        // a packet in flight finishes before termination takes over
        if (!busy_ff && (enable_n || oc_trip || charge_done))
        begin
          nxt_st   = wrxs_pkg::st_ept;
          nxt_gtmr = 32'h0;
          tx_go    = 1'b1;
          if (enable_n)
            tx_word = {`WRXS_HDR_EPT, `WRXS_EPT_UNKNOWN};
          else if (oc_trip)
          begin
            tx_word   = {`WRXS_HDR_EPT, `WRXS_OVERCURRENT_END_PACKET};
            nxt_ocm   = 1'b1;
            nxt_tries = 4'h1;
          end
          else
            tx_word = {`WRXS_HDR_EPT, `WRXS_EPT_CHARGED};
          nxt_ept = tx_word;
        end
        else if (tx_done && st_ff == wrxs_pkg::st_sig)
        begin
          nxt_st  = wrxs_pkg::st_id;
          tx_go   = 1'b1;
          tx_word = {`WRXS_HDR_ID, RX_ID};
        end
        else if (tx_done && st_ff == wrxs_pkg::st_id)
        begin
          nxt_st  = wrxs_pkg::st_cfg;
          tx_go   = 1'b1;
          tx_word = {`WRXS_HDR_CFG, CFG_WORD};
        end
        else if (tx_done && st_ff == wrxs_pkg::st_cfg)
        begin
          nxt_st   = wrxs_pkg::st_xfer;
          nxt_gtmr = 32'h0;
        end
        else if (st_ff == wrxs_pkg::st_xfer && !busy_ff)
        begin
          nxt_gtmr = gtmr_ff + 32'h1;
          if (gtmr_ff >= CE_GAP_CYC - 1)
          begin
            nxt_gtmr = 32'h0;
            tx_go    = 1'b1;
            tx_word  = {`WRXS_HDR_CE, tgt_ff - bridge_output_node_voltage_code};
          end
        end
      end
      wrxs_pkg::st_ept:
      begin
        if (!busy_ff)
        begin
          if (!ocm_ff || tries_ff == `WRXS_OC_TRIES)
            nxt_st = wrxs_pkg::st_done;
          else
          begin
            nxt_gtmr = gtmr_ff + 32'h1;
            if (gtmr_ff >= CE_GAP_CYC - 1)
            begin
              nxt_gtmr  = 32'h0;
              nxt_tries = tries_ff + 4'h1;
              tx_go     = 1'b1;
              tx_word   = ept_ff;
            end
          end
        end
      end
      wrxs_pkg::st_done: ;
      default: nxt_st = wrxs_pkg::st_off;
    endcase

    if (tx_go)
    begin
      nxt_busy = 1'b1;
      nxt_sh   = tx_word;
      nxt_mod  = tx_word[15];
      nxt_bitc = 5'h00;
      nxt_btmr = 32'h0;
    end

    // loss of the ping field ends everything; the next ping restarts
    if (!ping_power_good)
    begin
      nxt_st   = wrxs_pkg::st_off;
      nxt_busy = 1'b0;
      nxt_mod  = 1'b0;
      nxt_isrc = 1'b0;
    end

    nxt_dum  = ping_power_good &&
               (load_current_code < `WRXS_DUMMY_MIN);
    nxt_hiz  = nxt_st != wrxs_pkg::st_xfer;
    nxt_link = nxt_st == wrxs_pkg::st_xfer;
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff    <= wrxs_pkg::st_off;
      busy_ff  <= 1'b0;
      sh_ff    <= 16'h0000;
      bitc_ff  <= 5'h00;
      btmr_ff  <= 32'h0;
      gtmr_ff  <= 32'h0;
      mod_ff   <= 1'b0;
      dum_ff   <= 1'b0;
      isrc_ff  <= 1'b0;
      hiz_ff   <= 1'b1;
      link_ff  <= 1'b0;
      ocpe_ff  <= 1'b0;
      ilim_ff  <= `WRXS_ILIM_780;
      vsel_ff  <= 3'h2;
      hdr_ff   <= 1'b0;
      tgt_ff   <= `WRXS_BRIDGE_OUTPUT_NODE_NOLOAD;
      ocm_ff   <= 1'b0;
      tries_ff <= 4'h0;
      ept_ff   <= 16'h0000;
    end
    else
    begin
      st_ff    <= nxt_st;
      busy_ff  <= nxt_busy;
      sh_ff    <= nxt_sh;
      bitc_ff  <= nxt_bitc;
      btmr_ff  <= nxt_btmr;
      gtmr_ff  <= nxt_gtmr;
      mod_ff   <= nxt_mod;
      dum_ff   <= nxt_dum;
      isrc_ff  <= nxt_isrc;
      hiz_ff   <= nxt_hiz;
      link_ff  <= nxt_link;
      ocpe_ff  <= nxt_ocpe;
      ilim_ff  <= nxt_ilim;
      vsel_ff  <= nxt_vsel;
      hdr_ff   <= nxt_hdr;
      tgt_ff   <= nxt_tgt;
      ocm_ff   <= nxt_ocm;
      tries_ff <= nxt_tries;
      ept_ff   <= nxt_ept;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // open drain: only ever drives low, so the data flop stays at zero
  logic pli_lvl_ff;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      pli_lvl_ff <= 1'b0;
    else
      pli_lvl_ff <= 1'b0;
  end

  assign mod_drive               = mod_ff;
  assign dummy_load_en           = dum_ff;
  assign strap_current_en        = isrc_ff;
  assign out_hiz                 = hiz_ff;
  assign power_link_indicator_o  = pli_lvl_ff;
  assign power_link_indicator_oe = link_ff;
  assign ocp_enabled             = ocpe_ff;
  assign output_level_sel        = vsel_ff;
  assign headroom_hi             = hdr_ff;
  assign bridge_output_node_target             = tgt_ff;

endmodule : wrxs_seq

// ===== wrxs_seq_sva.sv
`timescale 1ns/100ps
`include "wrxs_defines.svh"
// ********
// checker
// ********
module wrxs_seq_chk (
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire logic       ping_power_good,
  input wire logic       enable_n,
  input wire logic [7:0] load_current_code,
  input wire logic       mod_drive,
  input wire logic       dummy_load_en,
  input wire logic       strap_current_en,
  input wire logic       out_hiz,
  input wire logic       power_link_indicator_o,
  input wire logic       power_link_indicator_oe,
  input wire logic       ocp_enabled,
  input wire logic [2:0] output_level_sel,
  input wire logic       headroom_hi,
  input wire logic [7:0] bridge_output_node_target
);
  logic [11:0] hi_cnt_ff;
  logic [11:0] nxt_hi_cnt;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // counts strap pulse cycles; a repetition of 2000 would not unroll
  always_comb nxt_hi_cnt = strap_current_en ? hi_cnt_ff + 12'h001 : 12'h000;
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n) hi_cnt_ff <= 12'h000;
    else hi_cnt_ff <= nxt_hi_cnt;
  property p_strap_len;
    $fell(strap_current_en) && ping_power_good |-> hi_cnt_ff == 12'h7d0;
  endproperty
  a_strap_len: assert property (p_strap_len)
    else $error("strap pulse length wrong");
  property p_quiet;
    strap_current_en |-> !mod_drive;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("modulation during strap read");
  property p_hiz_link;
    out_hiz != power_link_indicator_oe;
  endproperty
  a_hiz_link: assert property (p_hiz_link)
    else $error("output state and link pin disagree");
  property p_od_low;
    !power_link_indicator_o;
  endproperty
  a_od_low: assert property (p_od_low)
    else $error("link pin data not low");
  property p_en_stop;
    enable_n |-> ##[0:400] out_hiz;
  endproperty
  a_en_stop: assert property (p_en_stop)
    else $error("shutdown did not float output");
  property p_ping_off;
    !ping_power_good |=> !mod_drive && out_hiz;
  endproperty
  a_ping_off: assert property (p_ping_off)
    else $error("activity without ping power");
  property p_dummy_on;
    (ping_power_good && load_current_code < 8'h0a)[*2] |=> dummy_load_en;
  endproperty
  a_dummy_on: assert property (p_dummy_on)
    else $error("dummy load off at light load");
  property p_dummy_off;
    (load_current_code >= 8'h0a)[*2] |=> !dummy_load_en;
  endproperty
  a_dummy_off: assert property (p_dummy_off)
    else $error("dummy load on at heavy load");
  property p_sel_hold;
    ping_power_good && !strap_current_en && !$fell(strap_current_en)
      |-> $stable({ocp_enabled, output_level_sel, headroom_hi});
  endproperty
  a_sel_hold: assert property (p_sel_hold)
    else $error("strap selection moved outside strap read");
  property p_bridge_output_node_idle;
    !power_link_indicator_oe && !$past(power_link_indicator_oe)
      |-> bridge_output_node_target == `WRXS_BRIDGE_OUTPUT_NODE_NOLOAD;
  endproperty
  a_bridge_output_node_idle: assert property (p_bridge_output_node_idle)
    else $error("rectifier target not at no-load level");
  property p_cell;
    $changed(mod_drive) && ping_power_good
      |=> ($stable(mod_drive) || !ping_power_good)[*7];
  endproperty
  a_cell: assert property (p_cell)
    else $error("modulation cell too short");
endmodule : wrxs_seq_chk

bind wrxs_seq wrxs_seq_chk u_chk (.ref_clk, .rst_n, .ping_power_good,
  .enable_n, .load_current_code, .mod_drive, .dummy_load_en,
  .strap_current_en, .out_hiz, .power_link_indicator_o,
  .power_link_indicator_oe, .ocp_enabled, .output_level_sel, .headroom_hi,
  .bridge_output_node_target);

// ===== wrxs_tx_model.sv
`timescale 1ns/100ps
// ********
// transmitter side decoder
// ********
module wrxs_tx_model #(
  parameter int BIT_CYC = 8
)(
  input wire logic ref_clk,
  input wire logic ping_power_good,
  input wire logic strap_current_en,
  input wire logic mod_drive
);
  logic [15:0] pkts[$];
  // nrz cells have no preamble: after a gap the first rise marks bit 9,
  // so this only frames headers with six leading zero cells
  task automatic grab(input int lead);
    logic [15:0] w;
    w = 16'h0000;
    repeat (BIT_CYC / 2) @(posedge ref_clk);
    for (int i = 15 - lead; i >= 0; i--)
    begin
      w[i] = mod_drive;
      if (i > 0) repeat (BIT_CYC) @(posedge ref_clk);
    end
    repeat (BIT_CYC - BIT_CYC / 2) @(posedge ref_clk);
    pkts.push_back(w);
  endtask : grab
  always
  begin
    wait (strap_current_en);
    @(negedge strap_current_en);
    repeat (3) grab(0);
    while (ping_power_good)
    begin
      @(posedge mod_drive or negedge ping_power_good);
      if (mod_drive) grab(6);
    end
  end
endmodule : wrxs_tx_model

// ===== wrxs_seq_tb.sv
`timescale 1ns/100ps
// ********
// testbench
// ********
module wrxs_seq_tb;
  logic       ref_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       ping_power_good = 1'b0;
  logic       charge_done = 1'b0;
  logic       enable_n = 1'b0;
  logic [7:0] load_current_code = 8'h20;
  logic [7:0] bridge_output_node_voltage_code = 8'h78;
  logic [7:0] ioc_strap_code = 8'h30;
  logic [7:0] output_level_strap_strap_code = 8'h40;
  logic [7:0] hdr_strap_code = 8'h20;
  logic       mod_drive, dummy_load_en, strap_current_en, out_hiz;
  logic       power_link_indicator_o, power_link_indicator_oe;
  logic       ocp_enabled, headroom_hi;
  logic [2:0] output_level_sel;
  logic [7:0] bridge_output_node_target;
  int         n_fail = 0;
  int         num_checks = 0;
  // open-drain pin with pull-up
  wire        act_pin = power_link_indicator_oe ? power_link_indicator_o : 1'b1;

  always #25 ref_clk = ~ref_clk;

  wrxs_seq #(.BIT_CYC(8), .CE_GAP_CYC(50)) dut (.ref_clk, .rst_n,
    .ping_power_good, .charge_done, .enable_n, .load_current_code,
    .bridge_output_node_voltage_code, .ioc_strap_code, .output_level_strap_strap_code, .hdr_strap_code,
    .mod_drive, .dummy_load_en, .strap_current_en, .out_hiz,
    .power_link_indicator_o, .power_link_indicator_oe, .ocp_enabled,
    .output_level_sel, .headroom_hi, .bridge_output_node_target);
  wrxs_tx_model #(.BIT_CYC(8)) tx (.ref_clk, .ping_power_good,
    .strap_current_en, .mod_drive);

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #5;
  endtask : step

  task automatic wait_pkts(input int n);
    int k;
    k = 0;
    while (tx.pkts.size() < n && k < 3000)
    begin
      step(1);
      k++;
    end
    check("packet count", 16'(tx.pkts.size()), 16'(n));
  endtask : wait_pkts

  task automatic power_up;
    tx.pkts.delete();
    ping_power_good = 1'b1;
    step(3);
    check("strap current", strap_current_en, 1'b1);
    wait_pkts(3);
  endtask : power_up

  task automatic power_down;
    ping_power_good = 1'b0;
    enable_n = 1'b0;
    charge_done = 1'b0;
    load_current_code = 8'h20;
    step(20);
  endtask : power_down

  task automatic t_handshake;
    power_up;
    check("sig", tx.pkts[0], 16'h0178);
    check("id", tx.pkts[1], 16'h715a);
    check("cfg", tx.pkts[2], 16'h5106);
    wait_pkts(5);
    check("ce", tx.pkts[4], 16'h03f5);
    check("ocp", ocp_enabled, 1'b1);
    check("level", output_level_sel, 3'h1);
    check("headroom", headroom_hi, 1'b1);
    check("target", bridge_output_node_target, 8'h6d);
    check("hiz", out_hiz, 1'b0);
    check("link pin", act_pin, 1'b0);
    check("dummy", dummy_load_en, 1'b0);
    load_current_code = 8'h04;
    step(4);
    check("dummy", dummy_load_en, 1'b1);
    enable_n = 1'b1;
    wait_pkts(6);
    check("shutdown end", tx.pkts[5], 16'h0200);
    step(2);
    check("hiz", out_hiz, 1'b1);
    step(400);
    check("idle", 16'(tx.pkts.size()), 16'h0006);
    power_down;
  endtask : t_handshake

  task automatic t_charge;
    power_up;
    charge_done = 1'b1;
    wait_pkts(4);
    check("charge end", tx.pkts[3], 16'h0201);
    step(400);
    check("idle", 16'(tx.pkts.size()), 16'h0004);
    power_down;
  endtask : t_charge

  task automatic t_oc;
    power_up;
    load_current_code = 8'h41;
    wait_pkts(5);
    check("no trip", tx.pkts[4][15:8], 8'h03);
    load_current_code = 8'h42;
    wait_pkts(17);
    for (int i = 5; i < 17; i++)
      check("oc end", tx.pkts[i], 16'h0204);
    step(600);
    check("resends", 16'(tx.pkts.size()), 16'h0011);
    power_down;
  endtask : t_oc

  task automatic t_straps;
    ioc_strap_code = 8'h08;
    output_level_strap_strap_code = 8'h08;
    hdr_strap_code = 8'h08;
    power_up;
    load_current_code = 8'h60;
    wait_pkts(5);
    check("ocp", ocp_enabled, 1'b0);
    check("no trip", tx.pkts[4][15:8], 8'h03);
    check("level", output_level_sel, 3'h2);
    check("headroom", headroom_hi, 1'b0);
    check("target", bridge_output_node_target, 8'h76);
    power_down;
  endtask : t_straps

  task automatic wrap_up;
    if (n_fail == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up

  initial
  begin
    step(12);
    rst_n = 1'b1;
    step(2);
    t_handshake;
    t_charge;
    t_oc;
    t_straps;
    wrap_up;
  end

  // about 40000 cycles, well past the expected run
  initial
  begin
    #2000000;
    n_fail++;
    wrap_up;
  end
endmodule : wrxs_seq_tb
